// file: rtl/tmr_readout.sv
// temperature monitor readout: apb registers, background sensor sequencer
//
// What this block does
// - each adc_range_gain_bit picks a full scale of one reference (0) or two references (1).
// - a differential channel pair is flagged bipolar, spanning plus and minus the chosen full scale.
// - the three temperature inputs are measured over and over with no host request.
// - on_chip_sensor, first_remote_sensor and second_remote_sensor each own an enable bit.
// - a sensor whose enable is clear when the sequencer picks the next sensor is skipped; a sensor already picked is converted to the end.
// - monitoring runs on the secondary converter, apart from the primary converter.
// - at the end of each cycle a completion pulse goes out and the next cycle starts by itself.
// - each sensor result lands in its own data register.
// - results are 12-bit two's complement in eighths of a degree.
// - after reset the ideality correction is zero, giving ideality 1.008.
// - remote results are scaled by (300 - correction)/300, matching the effective ideality 1.008*300/(300 - correction).
// - a data register is held unchanged while a host transfer from it is in progress.
// - a clear series_resistance_cancel_bit drops the cancelling samples and shortens the cycle.
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_readout (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [15:0] ADC_RANGE_2X,
    output logic [1:0] ADC_PAIR_BIPOLAR,
    output logic SADC_START,
    output logic [1:0] SADC_SENSOR_SEL,
    output logic SADC_EXCITE_HIGH,
    input wire logic SADC_DONE,
    input wire logic [15:0] SADC_DATA,
    input wire logic XFER_BUSY,
    output logic CYCLE_DONE
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0] cfg_q;
    logic [7:0] nadj_q;
    logic [15:0] gain_q;
    logic [1:0] diff_q;
    logic [11:0] temp_q [3];
    logic [11:0] pend_q [3];
    logic [2:0] pend_v_q;
    logic [15:0] cycles_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    tmr_pkg::tmr_state_t state_q;
    tmr_pkg::tmr_sensor_t sel_q;
    logic [1:0] step_q;
    logic signed [15:0] acc_q;
    logic done_q;
    logic rc_q;

    logic setup;
    logic wr_acc;
    logic mapped;
    logic rc_on;
    logic remote;
    logic last_step;
    logic high_now;
    logic signed [15:0] acc_d;
    logic signed [15:0] kelvin8;
    logic [11:0] result;
    tmr_pkg::tmr_sensor_t nxt_sel;

    function automatic tmr_pkg::tmr_sensor_t next_en(input logic [1:0] from, input logic [2:0] en);
        tmr_pkg::tmr_sensor_t r;
        r = tmr_pkg::SENS_NONE;
        for (int i = 2; i >= 0; i--)
        begin
            if (en[i] && (2'(i) >= from))
            begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return (a == `TMR_OFS_CFG) || (a == `TMR_OFS_NADJ) || (a == `TMR_OFS_GAIN) ||
            (a == `TMR_OFS_DIFF) || (a == `TMR_OFS_TEMP_LT) || (a == `TMR_OFS_TEMP_D1) ||
            (a == `TMR_OFS_TEMP_D2) || (a == `TMR_OFS_STATUS);
    endfunction

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    assign setup = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PWRITE && !pslverr_q;
    assign mapped = is_mapped(PADDR);
    assign PREADY = 1'b1;
    assign PRDATA = prdata_q;
    assign PSLVERR = PSEL && PENABLE && pslverr_q;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (setup)
        begin
            pslverr_q <= !mapped;
            prdata_q <= 32'h00000000;
            case (PADDR)
                `TMR_OFS_CFG: prdata_q[3:0] <= cfg_q;
                `TMR_OFS_NADJ: prdata_q[7:0] <= nadj_q;
                `TMR_OFS_GAIN: prdata_q[15:0] <= gain_q;
                `TMR_OFS_DIFF: prdata_q[1:0] <= diff_q;
                `TMR_OFS_TEMP_LT: prdata_q[11:0] <= temp_q[0];
                `TMR_OFS_TEMP_D1: prdata_q[11:0] <= temp_q[1];
                `TMR_OFS_TEMP_D2: prdata_q[11:0] <= temp_q[2];
                `TMR_OFS_STATUS: prdata_q <= {13'h0000, sel_q, state_q != tmr_pkg::ST_IDLE, cycles_q};
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            cfg_q <= `TMR_RST_CFG;
            nadj_q <= `TMR_RST_NADJ;
            gain_q <= `TMR_RST_GAIN;
            diff_q <= `TMR_RST_DIFF;
        end
        else if (wr_acc)
        begin
            case (PADDR)
                `TMR_OFS_CFG: cfg_q <= PWDATA[3:0];
                `TMR_OFS_NADJ: nadj_q <= PWDATA[7:0];
                `TMR_OFS_GAIN: gain_q <= PWDATA[15:0];
                `TMR_OFS_DIFF: diff_q <= PWDATA[1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // primary converter range controls
    // ------------------------------------------------------------
    assign ADC_RANGE_2X = gain_q;
    assign ADC_PAIR_BIPOLAR = diff_q;

    // ------------------------------------------------------------
    // background sequencer on the secondary converter
    // ------------------------------------------------------------
    // cancel mode held per sensor, a mid-cycle write cannot cut a chopped sequence
    assign rc_on = rc_q;
    assign remote = sel_q != tmr_pkg::SENS_LOCAL;
    assign last_step = !remote || (rc_on ? (step_q == 2'h3) : (step_q == 2'h1));
    assign high_now = remote && ((step_q == 2'h1) || (step_q == 2'h2));
    assign acc_d = high_now ? acc_q + $signed(SADC_DATA) : acc_q - $signed(SADC_DATA);
    assign kelvin8 = !remote ? $signed(SADC_DATA) : (rc_on ? (acc_d >>> 1) : acc_d);
    assign nxt_sel = next_en(2'(sel_q + 2'h1), cfg_q[2:0]);
    assign SADC_START = state_q == tmr_pkg::ST_START;
    assign SADC_SENSOR_SEL = sel_q;
    assign SADC_EXCITE_HIGH = high_now && (state_q != tmr_pkg::ST_IDLE);
    assign CYCLE_DONE = done_q;

    tmr_temp_calc u_calc (
        .kelvin8(kelvin8),
        .nadj(nadj_q),
        .apply_corr(remote),
        .celsius8(result)
    );

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            state_q <= tmr_pkg::ST_IDLE;
            sel_q <= tmr_pkg::SENS_LOCAL;
            step_q <= 2'h0;
            acc_q <= 16'sh0000;
            done_q <= 1'b0;
            rc_q <= 1'b0;
            cycles_q <= 16'h0000;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                tmr_pkg::ST_IDLE:
                begin
                    if (cfg_q[2:0] != 3'h0)
                    begin
                        sel_q <= next_en(2'h0, cfg_q[2:0]);
                        rc_q <= cfg_q[`TMR_CFG_RC];
                        step_q <= 2'h0;
                        acc_q <= 16'sh0000;
                        state_q <= tmr_pkg::ST_START;
                    end
                end
                tmr_pkg::ST_START:
                begin
                    state_q <= tmr_pkg::ST_WAIT;
                end
                tmr_pkg::ST_WAIT:
                begin
                    if (SADC_DONE)
                    begin
                        acc_q <= acc_d;
                        step_q <= 2'(step_q + 2'h1);
                        state_q <= last_step ? tmr_pkg::ST_NEXT : tmr_pkg::ST_START;
                    end
                end
                tmr_pkg::ST_NEXT:
                begin
                    step_q <= 2'h0;
                    acc_q <= 16'sh0000;
                    if (nxt_sel == tmr_pkg::SENS_NONE)
                    begin
                        done_q <= 1'b1;
                        cycles_q <= 16'(cycles_q + 16'h0001);
                        state_q <= tmr_pkg::ST_IDLE;
                    end
                    else
                    begin
                        sel_q <= nxt_sel;
                        rc_q <= cfg_q[`TMR_CFG_RC];
                        state_q <= tmr_pkg::ST_START;
                    end
                end
                default: state_q <= tmr_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // result registers, frozen during a host transfer
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            pend_v_q <= 3'h0;
            for (int i = 0; i < 3; i++)
            begin
                pend_q[i] <= `TMR_RST_TEMP;
                temp_q[i] <= `TMR_RST_TEMP;
            end
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (!XFER_BUSY && pend_v_q[i])
                begin
                    temp_q[i] <= pend_q[i];
                end
                if (state_q == tmr_pkg::ST_WAIT && SADC_DONE && last_step && sel_q == 2'(i))
                begin
                    pend_q[i] <= result;
                    pend_v_q[i] <= 1'b1;
                end
                else if (!XFER_BUSY)
                begin
                    pend_v_q[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    gain_write_a: assert property (@(posedge CLK) disable iff (RESET)
        (wr_acc && PADDR == `TMR_OFS_GAIN) |=> ADC_RANGE_2X == $past(PWDATA[15:0]))
        else $error("range gain bits not taken from write");
    pair_write_a: assert property (@(posedge CLK) disable iff (RESET)
        (wr_acc && PADDR == `TMR_OFS_DIFF) |=> ADC_PAIR_BIPOLAR == $past(PWDATA[1:0]))
        else $error("bipolar pair flags not taken from write");
    skip_disabled_a: assert property (@(posedge CLK) disable iff (RESET)
        (SADC_START && step_q == 2'h0 && !$past(wr_acc)) |-> cfg_q[SADC_SENSOR_SEL])
        else $error("disabled sensor converted");
    auto_restart_a: assert property (@(posedge CLK) disable iff (RESET)
        (CYCLE_DONE && cfg_q[2:0] != 3'h0 && !wr_acc) |-> ##[1:2] SADC_START)
        else $error("next cycle did not start");
    freeze_busy_a: assert property (@(posedge CLK) disable iff (RESET)
        XFER_BUSY |=> (temp_q[0] == $past(temp_q[0]) && temp_q[1] == $past(temp_q[1]) &&
            temp_q[2] == $past(temp_q[2])))
        else $error("data register changed during transfer");
    short_cycle_a: assert property (@(posedge CLK) disable iff (RESET)
        (SADC_START && !rc_on) |-> step_q < 2'h2)
        else $error("cancel samples taken with cancel off");
    excite_remote_a: assert property (@(posedge CLK) disable iff (RESET)
        SADC_EXCITE_HIGH |-> SADC_SENSOR_SEL != tmr_pkg::SENS_LOCAL)
        else $error("high excitation on local sensor");
    corr_reset_a: assert property (@(posedge CLK)
        RESET |=> nadj_q == 8'h00)
        else $error("correction not zero after reset");
    order_fixed_a: assert property (@(posedge CLK) disable iff (RESET)
        (state_q == tmr_pkg::ST_NEXT && nxt_sel != tmr_pkg::SENS_NONE) |=> sel_q > $past(sel_q))
        else $error("sensor order not ascending");
    store_result_a: assert property (@(posedge CLK) disable iff (RESET)
        (state_q == tmr_pkg::ST_WAIT && SADC_DONE && last_step && !XFER_BUSY) ##1 !XFER_BUSY
            |=> temp_q[$past(sel_q, 2)] == $past(result, 2))
        else $error("result not stored in its register");

endmodule

// file: rtl/tmr_cfg.svh
// register map, field positions, reset values and arithmetic constants
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

`define TMR_OFS_CFG 12'h000
`define TMR_OFS_NADJ 12'h004
`define TMR_OFS_GAIN 12'h008
`define TMR_OFS_DIFF 12'h00c
`define TMR_OFS_TEMP_LT 12'h010
`define TMR_OFS_TEMP_D1 12'h014
`define TMR_OFS_TEMP_D2 12'h018
`define TMR_OFS_STATUS 12'h01c

`define TMR_CFG_LOCAL_EN 0
`define TMR_CFG_REMOTE1_EN 1
`define TMR_CFG_REMOTE2_EN 2
`define TMR_CFG_RC 3
`define TMR_STAT_BUSY 16
`define TMR_STAT_SEL_LO 17

`define TMR_RST_CFG 4'hf
`define TMR_RST_NADJ 8'h00
`define TMR_RST_GAIN 16'h0000
`define TMR_RST_DIFF 2'h0
`define TMR_RST_TEMP 12'h000

`define TMR_IDEAL_DEN 10'h12c
`define TMR_KELVIN_OFS8 16'h0889
`define TMR_TEMP_MAX 16'h07ff
`define TMR_TEMP_MIN 16'hf800

`endif

// file: rtl/tmr_pkg.sv
// shared types of the temperature monitor readout
package tmr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_WAIT,
        ST_NEXT
    } tmr_state_t;

    typedef logic [1:0] tmr_sensor_t;

    localparam tmr_sensor_t SENS_LOCAL = 2'h0;
    localparam tmr_sensor_t SENS_REMOTE1 = 2'h1;
    localparam tmr_sensor_t SENS_REMOTE2 = 2'h2;
    localparam tmr_sensor_t SENS_NONE = 2'h3;

endpackage

// file: rtl/tmr_temp_calc.sv
// kelvin-eighths to celsius-eighths with ideality correction
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_temp_calc (
    input wire logic signed [15:0] kelvin8,
    input wire logic signed [7:0] nadj,
    input wire logic apply_corr,
    output logic [11:0] celsius8
);

    // ------------------------------------------------------------
    // ideality correction: T scales by (300 - n) / 300
    // ------------------------------------------------------------
    logic signed [10:0] factor;
    logic signed [26:0] prod;
    logic signed [26:0] scaled;
    logic signed [26:0] cels;

    function automatic logic [11:0] sat12(input logic signed [26:0] v);
        logic [11:0] r;
        r = v[11:0];
        if (v > $signed({{11{1'b0}}, `TMR_TEMP_MAX}))
        begin
            r = 12'(`TMR_TEMP_MAX);
        end
        else if (v < $signed({{11{1'b1}}, `TMR_TEMP_MIN}))
        begin
            r = 12'(`TMR_TEMP_MIN);
        end
        return r;
    endfunction

    always_comb
    begin
        factor = $signed({1'b0, `TMR_IDEAL_DEN}) - 11'(nadj);
        prod = 27'(kelvin8) * 27'(factor);
        scaled = apply_corr ? 27'(prod / $signed({17'h00000, `TMR_IDEAL_DEN})) : 27'(kelvin8);
        cels = scaled - $signed({11'h000, `TMR_KELVIN_OFS8});
        celsius8 = sat12(cels);
    end

endmodule

// file: sim/tmr_sadc_model.sv
// behavioural secondary converter with one local and two remote junctions
`timescale 1ns/1ps

module tmr_sadc_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [1:0] sel,
    input wire logic excite_high,
    output logic done,
    output logic [15:0] data,
    input wire logic [15:0] lt_k8,
    input wire logic [15:0] r1_diff,
    input wire logic [15:0] r2_diff,
    input wire logic [15:0] base,
    input wire logic [15:0] lag
);
    logic busy_q;
    logic excite_q;
    logic [1:0] sel_q;
    logic [15:0] cnt_q;
    logic [15:0] diff;

    // --------
    // conversion
    // --------
    assign diff = (sel_q == 2'h1) ? r1_diff : r2_diff;

    initial
    begin
        done = 1'b0;
        data = 16'h5a5a;
    end

    always @(posedge clk)
    begin
        done <= 1'b0;
        // no sample pending: data wobbles
        data <= ~data;
        if (reset)
            busy_q <= 1'b0;
        else if (start)
        begin
            busy_q <= 1'b1;
            cnt_q <= lag;
            sel_q <= sel;
            excite_q <= excite_high;
        end
        else if (busy_q && cnt_q == 16'h0)
        begin
            busy_q <= 1'b0;
            done <= 1'b1;
            data <= (sel_q == 2'h0) ? lt_k8 : base + (excite_q ? diff : 16'h0);
        end
        else if (busy_q)
            cnt_q <= cnt_q - 16'h1;
    end
endmodule

// file: sim/test_tmr_readout.sv
// self-checking testbench of the temperature monitor readout
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module test_tmr_readout;
    logic CLK, RESET, PSEL, PENABLE, PWRITE, XFER_BUSY, PREADY, PSLVERR;
    logic SADC_START, SADC_EXCITE_HIGH, SADC_DONE, CYCLE_DONE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [15:0] ADC_RANGE_2X, SADC_DATA, lt_k8, r1_diff, r2_diff, base, lag, gain;
    logic [1:0] ADC_PAIR_BIPOLAR, SADC_SENSOR_SEL, prev_sel;
    logic [2:0] en_mask;
    logic [3:0] gap;
    logic [15:0] done_cnt;
    logic [32:0] exp_q[$];
    int error_cnt, checks_done, cyc, r2_cnt, r2_exp, seed_r;

    tmr_readout DUT (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .ADC_RANGE_2X(ADC_RANGE_2X), .ADC_PAIR_BIPOLAR(ADC_PAIR_BIPOLAR), .SADC_START(SADC_START),
        .SADC_SENSOR_SEL(SADC_SENSOR_SEL), .SADC_EXCITE_HIGH(SADC_EXCITE_HIGH), .SADC_DONE(SADC_DONE),
        .SADC_DATA(SADC_DATA), .XFER_BUSY(XFER_BUSY), .CYCLE_DONE(CYCLE_DONE));

    tmr_sadc_model sensors (.clk(CLK), .reset(RESET), .start(SADC_START), .sel(SADC_SENSOR_SEL),
        .excite_high(SADC_EXCITE_HIGH), .done(SADC_DONE), .data(SADC_DATA), .lt_k8(lt_k8),
        .r1_diff(r1_diff), .r2_diff(r2_diff), .base(base), .lag(lag));

    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // --------
    // tasks
    // --------
    task automatic close_out();
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [32:0] got, input logic [32:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [32:0] exp);
        if (!wr)
            exp_q.push_back(exp);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= addr;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK iff PREADY === 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wait_done(input int n);
        repeat (n)
        begin
            @(negedge CLK);
            while (CYCLE_DONE !== 1'b1)
                @(negedge CLK);
        end
    endtask

    // --------
    // watchers
    // --------
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            close_out();
        end
        if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1 && PWRITE === 1'b0)
            check({PSLVERR, PRDATA}, exp_q.pop_front(), "apb read");
        if (CYCLE_DONE === 1'b1)
        begin
            if (r2_exp != 0)
                check(r2_cnt, r2_exp, "remote2 samples");
            r2_cnt = 0;
            done_cnt <= done_cnt + 16'h0001;
            prev_sel <= 2'h0;
            gap <= 4'h1;
        end
        else if (gap != 4'h0 && en_mask != 3'h0)
        begin
            check(gap < 4'h4, 1'b1, "restart gap");
            gap <= gap + 4'h1;
        end
        if (SADC_START === 1'b1)
        begin
            check(en_mask[SADC_SENSOR_SEL] && SADC_SENSOR_SEL >= prev_sel, 1'b1, "pick");
            prev_sel <= SADC_SENSOR_SEL;
            gap <= 4'h0;
            if (SADC_SENSOR_SEL == 2'h2)
                r2_cnt++;
        end
    end

    // --------
    // main sequence
    // --------
    initial
    begin
        RESET = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        XFER_BUSY = 1'b0;
        seed_r = $urandom(45);
        lt_k8 = 16'h0951;
        r1_diff = 16'h0881;
        r2_diff = 16'h0a19;
        base = 16'($urandom() & 32'h0fff);
        lag = 16'($urandom_range(15, 0));
        gain = 16'($urandom());
        en_mask = 3'h7;
        prev_sel = 2'h0;
        gap = 4'h0;
        done_cnt = 16'h0000;
        r2_exp = 4;
        repeat (20) @(posedge CLK);
        RESET <= 1'b0;
        apb(0, `TMR_OFS_TEMP_D2, 0, 33'h0);
        apb(0, `TMR_OFS_CFG, 0, 33'h0f);
        apb(0, `TMR_OFS_NADJ, 0, 33'h0);
        apb(0, `TMR_OFS_GAIN, 0, 33'h0);
        apb(0, 12'h020, 0, 33'h100000000);
        apb(1, `TMR_OFS_GAIN, {16'h0, gain}, 0);
        apb(1, `TMR_OFS_DIFF, 32'h2, 0);
        @(negedge CLK);
        check(ADC_RANGE_2X, gain, "range gain");
        check(ADC_PAIR_BIPOLAR, 2'h2, "pair mode");
        wait_done(2);
        apb(0, `TMR_OFS_TEMP_LT, 0, 33'h0c8);
        apb(0, `TMR_OFS_TEMP_D1, 0, 33'hff8);
        apb(0, `TMR_OFS_TEMP_D2, 0, 33'h190);
        @(posedge CLK);
        r1_diff <= 16'h0bb8;
        apb(1, `TMR_OFS_NADJ, 32'h0a, 0);
        wait_done(2);
        apb(0, `TMR_OFS_NADJ, 0, 33'h0a);
        apb(0, `TMR_OFS_TEMP_D1, 0, 33'h2cb);
        apb(0, `TMR_OFS_TEMP_LT, 0, 33'h0c8);
        apb(1, `TMR_OFS_NADJ, 32'h80, 0);
        wait_done(2);
        apb(0, `TMR_OFS_TEMP_D1, 0, 33'h7ff);
        r2_exp = 0;
        lag <= 16'($urandom_range(15, 0));
        apb(1, `TMR_OFS_CFG, 32'h4, 0);
        wait_done(2);
        en_mask = 3'h4;
        r2_exp = 2;
        wait_done(3);
        apb(0, `TMR_OFS_CFG, 0, 33'h4);
        r2_exp = 0;
        en_mask = 3'h7;
        apb(1, `TMR_OFS_CFG, 32'hf, 0);
        wait_done(2);
        r2_exp = 4;
        @(posedge CLK);
        XFER_BUSY <= 1'b1;
        lt_k8 <= 16'h0a19;
        wait_done(2);
        apb(0, `TMR_OFS_TEMP_LT, 0, 33'h0c8);
        @(posedge CLK);
        XFER_BUSY <= 1'b0;
        wait_done(2);
        apb(0, `TMR_OFS_TEMP_LT, 0, 33'h190);
        r2_exp = 0;
        apb(1, `TMR_OFS_CFG, 32'h4, 0);
        wait_done(2);
        apb(1, `TMR_OFS_CFG, 32'h0, 0);
        wait_done(1);
        en_mask = 3'h0;
        repeat (2) @(posedge CLK);
        apb(0, `TMR_OFS_STATUS, 0, {17'h00004, done_cnt});
        close_out();
    end
endmodule
